// [hdl/cache_enum_regs.svh]
// Constants for the cache parameter enumeration block
`ifndef CACHE_ENUM_REGS_SVH
`define CACHE_ENUM_REGS_SVH
// Leaf numbers
`define LEAF_CACHE_PARAMS 32'h0000_0004
`define LEAF_LIMIT_LOW 32'h0000_0003
`define LEAF_EXT_BASE 32'h8000_0000
// Misc-enable control bit that limits visible leaves
`define MISC_LEAF_LIMIT_BIT 22
// First result word fields
`define TYPE_LSB 0
`define TYPE_MSB 4
`define LEVEL_LSB 5
`define LEVEL_MSB 7
`define SELF_INIT_BIT 8
`define FULL_ASSOC_BIT 9
`define RSVD_A_LSB 10
`define RSVD_A_MSB 13
`define SHARE_LSB 14
`define SHARE_MSB 25
`define CORES_LSB 26
`define CORES_MSB 31
// Second result word fields
`define LINE_LSB 0
`define LINE_MSB 11
`define PART_LSB 12
`define PART_MSB 21
`define WAYS_LSB 22
`define WAYS_MSB 31
// Cache type codes
`define CTYPE_NULL 5'h00
`define CTYPE_DATA 5'h01
`define CTYPE_INSTR 5'h02
`define CTYPE_UNIFIED 5'h03
// Number of described cache entries
`define NUM_CACHES 3
`define SUBIDX_W 32
`endif

// [hdl/cache_enum_pkg.sv]
// Types for the cache parameter enumeration block
`default_nettype none
package cache_enum_pkg;
   typedef struct packed {
      logic [31:0] leaf;
      logic [31:0] sub_index;
   } query_t;
   typedef struct packed {
      logic [31:0] first_result_word;
      logic [31:0] second_result_word;
      logic [31:0] set_count_word;
      logic [31:0] reserved_word;
   } result_t;
   typedef struct packed {
      logic [4:0] ctype;
      logic [2:0] level;
      logic self_init;
      logic full_assoc;
      logic [11:0] share_m1;
      logic [5:0] cores_m1;
      logic [11:0] line_m1;
      logic [9:0] part_m1;
      logic [9:0] ways_m1;
      logic [31:0] sets_m1;
   } cache_desc_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_DONE = 2'b10
   } qstate_t;
endpackage
`default_nettype wire

// [hdl/cache_desc_rom.sv]
// Constant table of cache level descriptions selected by sub-index
`timescale 1ns/1ps
`default_nettype none
`include "cache_enum_regs.svh"
module cache_desc_rom
   import cache_enum_pkg::*;
(
   input wire logic [31:0] sub_index,
   output cache_enum_pkg::cache_desc_t desc
);
   import cache_enum_pkg::*;

   // Plain defaults; a real part sets these per product
   localparam cache_desc_t TABLE [`NUM_CACHES] = '{
      '{ctype: `CTYPE_DATA, level: 3'h1, self_init: 1'b1, full_assoc: 1'b0, share_m1: 12'h001,
        cores_m1: 6'h01, line_m1: 12'h03f, part_m1: 10'h000, ways_m1: 10'h007, sets_m1: 32'h0000_003f},
      '{ctype: `CTYPE_INSTR, level: 3'h1, self_init: 1'b1, full_assoc: 1'b0, share_m1: 12'h001,
        cores_m1: 6'h01, line_m1: 12'h03f, part_m1: 10'h000, ways_m1: 10'h007, sets_m1: 32'h0000_003f},
      '{ctype: `CTYPE_UNIFIED, level: 3'h2, self_init: 1'b1, full_assoc: 1'b0, share_m1: 12'h003,
        cores_m1: 6'h01, line_m1: 12'h03f, part_m1: 10'h000, ways_m1: 10'h00f, sets_m1: 32'h0000_0fff}
   };
   // Indices past the table give the null descriptor, which ends the walk
   always_comb begin
      desc = '0;
      if (sub_index < `NUM_CACHES) begin
         desc = TABLE[sub_index[1:0]];
      end
   end
endmodule
`default_nettype wire

// [hdl/cache_enum.sv]
// Cache parameter enumeration answering the identification query
//
// Behaviour
// - First word bits 4:0 give cache type, bits 7:5 level from one.
// - First word bit 8 set when the level self-initialises.
// - First word bit 9 set when the level is fully associative.
// - First word bits 25:14 give sharing processors minus one.
// - First word bits 31:26 give cores per package minus one.
// - Second word bits 11:0 give coherency line size minus one.
// - Second word bits 21:12 give line partitions minus one.
// - Second word bits 31:22 give ways minus one.
// - Leaves above 3, below extended range, visible only when limit bit clear.
// - Size equals product of ways, partitions, line size and sets, each plus one.
`timescale 1ns/1ps
`default_nettype none
`include "cache_enum_regs.svh"
module cache_enum
   import cache_enum_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic query_valid,
   input wire cache_enum_pkg::query_t query,
   input wire logic [31:0] misc_enable,
   output logic result_valid,
   output logic leaf_hidden,
   output cache_enum_pkg::result_t result
);
   import cache_enum_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Decoding
   cache_desc_t desc;
   result_t res_nxt, res_r;
   logic valid_nxt, valid_r, hidden_nxt, hidden_r;
   qstate_t st_r, st_nxt;

   // Sub-index goes straight into the table lookup
   cache_desc_rom u_rom (
      .sub_index(query.sub_index),
      .desc(desc)
   );

   // Mid-range leaves are hidden while the limit bit is set
   function automatic logic leaf_visible(input logic [31:0] leaf, input logic [31:0] misc);
      leaf_visible = !((leaf > `LEAF_LIMIT_LOW) && (leaf < `LEAF_EXT_BASE)) || !misc[`MISC_LEAF_LIMIT_BIT];
   endfunction

   // Pack a descriptor into the four result words
   function automatic result_t pack(input cache_desc_t d);
      result_t r;
      r = '0; // Reserved bits and fourth word stay zero
      r.first_result_word[`TYPE_MSB:`TYPE_LSB] = d.ctype;
      r.first_result_word[`LEVEL_MSB:`LEVEL_LSB] = d.level;
      r.first_result_word[`SELF_INIT_BIT] = d.self_init;
      r.first_result_word[`FULL_ASSOC_BIT] = d.full_assoc;
      r.first_result_word[`SHARE_MSB:`SHARE_LSB] = d.share_m1;
      r.first_result_word[`CORES_MSB:`CORES_LSB] = d.cores_m1;
      r.second_result_word[`LINE_MSB:`LINE_LSB] = d.line_m1;
      r.second_result_word[`PART_MSB:`PART_LSB] = d.part_m1;
      r.second_result_word[`WAYS_MSB:`WAYS_LSB] = d.ways_m1;
      r.set_count_word = d.sets_m1;
      pack = r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Answer path: one cycle from query to result
   always_comb begin
      res_nxt = res_r;
      valid_nxt = 1'b0;
      hidden_nxt = hidden_r;
      st_nxt = ST_IDLE;
      case (st_r)
         ST_IDLE, ST_DONE: begin
            if (query_valid) begin
               valid_nxt = 1'b1;
               st_nxt = ST_DONE;
               // Hidden leaf answers all zero rather than stale data
               hidden_nxt = !leaf_visible(query.leaf, misc_enable);
               if (query.leaf == `LEAF_CACHE_PARAMS && !hidden_nxt) begin
                  res_nxt = pack(desc); // Fields are taken from one geometry entry
               end else begin
                  res_nxt = '0;
               end
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   // Registers only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         res_r <= '0;
         valid_r <= 1'b0;
         hidden_r <= 1'b0;
         st_r <= ST_IDLE;
      end else begin
         res_r <= res_nxt;
         valid_r <= valid_nxt;
         hidden_r <= hidden_nxt;
         st_r <= st_nxt;
      end
   end

   assign result = res_r;
   assign result_valid = valid_r;
   assign leaf_hidden = hidden_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_param_query;
      query_valid && query.leaf == `LEAF_CACHE_PARAMS && !misc_enable[`MISC_LEAF_LIMIT_BIT];
   endsequence

   property p_answer_next;
      @(posedge clk) disable iff (sys_rst) query_valid |=> result_valid;
   endproperty
   a_answer_next: assert property (p_answer_next) else $error("No answer after query");

   property p_type_level;
      @(posedge clk) disable iff (sys_rst)
         s_param_query |=> result.first_result_word[`TYPE_MSB:`TYPE_LSB] == $past(desc.ctype)
         && result.first_result_word[`LEVEL_MSB:`LEVEL_LSB] == $past(desc.level);
   endproperty
   a_type_level: assert property (p_type_level) else $error("Type or level wrong");

   property p_flags;
      @(posedge clk) disable iff (sys_rst)
         s_param_query |=> result.first_result_word[`SELF_INIT_BIT] == $past(desc.self_init)
         && result.first_result_word[`FULL_ASSOC_BIT] == $past(desc.full_assoc);
   endproperty
   a_flags: assert property (p_flags) else $error("Flag bits wrong");

   property p_sharing;
      @(posedge clk) disable iff (sys_rst)
         s_param_query |=> result.first_result_word[`SHARE_MSB:`SHARE_LSB] == $past(desc.share_m1)
         && result.first_result_word[`CORES_MSB:`CORES_LSB] == $past(desc.cores_m1);
   endproperty
   a_sharing: assert property (p_sharing) else $error("Sharing fields wrong");

   property p_geometry;
      @(posedge clk) disable iff (sys_rst)
         s_param_query |=> result.second_result_word == {$past(desc.ways_m1), $past(desc.part_m1), $past(desc.line_m1)}
         && result.set_count_word == $past(desc.sets_m1);
   endproperty
   a_geometry: assert property (p_geometry) else $error("Geometry fields wrong");

   property p_hidden;
      @(posedge clk) disable iff (sys_rst)
         query_valid && misc_enable[`MISC_LEAF_LIMIT_BIT] && query.leaf == `LEAF_CACHE_PARAMS
         |=> leaf_hidden && result == '0;
   endproperty
   a_hidden: assert property (p_hidden) else $error("Hidden leaf answered");

   property p_reserved;
      @(posedge clk) disable iff (sys_rst)
         result_valid |-> result.reserved_word == '0 && result.first_result_word[`RSVD_A_MSB:`RSVD_A_LSB] == '0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("Reserved bits nonzero");

   property p_null_past_end;
      @(posedge clk) disable iff (sys_rst)
         s_param_query ##0 (query.sub_index >= `NUM_CACHES)
         |=> result.first_result_word[`TYPE_MSB:`TYPE_LSB] == `CTYPE_NULL;
   endproperty
   a_null_past_end: assert property (p_null_past_end) else $error("Null type missing");

   // Range that the limit bit can hide: a request with its leaf range and the bit, all in one cycle
   sequence s_hidden_query;
      query_valid && query.leaf > `LEAF_LIMIT_LOW && query.leaf < `LEAF_EXT_BASE
      && misc_enable[`MISC_LEAF_LIMIT_BIT];
   endsequence

   property p_no_spurious;
      @(posedge clk) disable iff (sys_rst) !query_valid |=> !result_valid;
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("Answer without query");

   // Left without disable so that the reset itself is watched
   property p_reset_clear;
      @(posedge clk) sys_rst |=> !result_valid && !leaf_hidden && result == '0;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("Reset left an answer");

   property p_hidden_range;
      @(posedge clk) disable iff (sys_rst) s_hidden_query |=> leaf_hidden && result == '0;
   endproperty
   a_hidden_range: assert property (p_hidden_range) else $error("Hidden range answered");

   property p_visible_flag;
      @(posedge clk) disable iff (sys_rst)
         query_valid && (query.leaf <= `LEAF_LIMIT_LOW || query.leaf >= `LEAF_EXT_BASE
         || !misc_enable[`MISC_LEAF_LIMIT_BIT]) |=> !leaf_hidden;
   endproperty
   a_visible_flag: assert property (p_visible_flag) else $error("Visible leaf flagged hidden");

   property p_other_leaf_zero;
      @(posedge clk) disable iff (sys_rst) query_valid && query.leaf != `LEAF_CACHE_PARAMS |=> result == '0;
   endproperty
   a_other_leaf_zero: assert property (p_other_leaf_zero) else $error("Other leaf not zero");

   property p_known_type;
      @(posedge clk) disable iff (sys_rst)
         result_valid |-> result.first_result_word[`TYPE_MSB:`TYPE_LSB] <= `CTYPE_UNIFIED;
   endproperty
   a_known_type: assert property (p_known_type) else $error("Reserved cache type code");

   property p_level_from_one;
      @(posedge clk) disable iff (sys_rst)
         result_valid && result.first_result_word[`TYPE_MSB:`TYPE_LSB] != `CTYPE_NULL
         |-> result.first_result_word[`LEVEL_MSB:`LEVEL_LSB] != '0;
   endproperty
   a_level_from_one: assert property (p_level_from_one) else $error("Cache level zero");

   // Sampled reset kept in the antecedent: a reset edge legally changes the answer
   property p_hold_answer;
      @(posedge clk) disable iff (sys_rst)
         !query_valid && !sys_rst |=> $stable(result) && $stable(leaf_hidden);
   endproperty
   a_hold_answer: assert property (p_hold_answer) else $error("Answer changed without query");
endmodule
`default_nettype wire

// [tb/test_cache_enum.sv]
// Self-checking testbench for the cache parameter enumeration block
`timescale 1ns/1ps
`default_nettype none
module test_cache_enum;
   import cache_enum_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic query_valid = 1'b0;
   query_t query = '0;
   logic [31:0] misc_enable = 32'h0;
   logic result_valid;
   logic leaf_hidden;
   result_t result;
   int miscompares = 0;
   int n_compared = 0;
   localparam logic [31:0] LIMIT = 32'h0040_0000; // Leaf limit bit set
   ////////////////////////////////////////////////////////////////
   // Clock and device under test
   always #2.5 clk = ~clk;
   cache_enum DUT (
      .clk(clk),
      .sys_rst(sys_rst),
      .query_valid(query_valid),
      .query(query),
      .misc_enable(misc_enable),
      .result_valid(result_valid),
      .leaf_hidden(leaf_hidden),
      .result(result)
   );
   ////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One query, answer looked at in the single cycle that it stands
   task automatic ask(input logic [31:0] leaf, input logic [31:0] idx, input logic [31:0] misc);
      @(posedge clk);
      query_valid <= 1'b1;
      query <= '{leaf: leaf, sub_index: idx};
      misc_enable <= misc;
      @(posedge clk);
      query_valid <= 1'b0;
      #1;
      chk({31'h0, result_valid}, 32'h1);
   endtask
   task automatic desc(input logic [4:0] t, input logic [2:0] lv);
      chk({24'h0, result.first_result_word[7:0]}, {24'h0, lv, t});
      chk({28'h0, result.first_result_word[13:10]}, 32'h0);
      chk(result.reserved_word, 32'h0);
      chk({31'h0, leaf_hidden}, 32'h0);
   endtask
   // Whole answer zero, hidden flag as expected
   task automatic zero(input logic hid);
      chk({31'h0, leaf_hidden}, {31'h0, hid});
      chk(result.first_result_word | result.second_result_word, 32'h0);
      chk(result.set_count_word | result.reserved_word, 32'h0);
   endtask
   task automatic conclude;
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      chk({31'h0, result_valid}, 32'h0);
      chk(result.first_result_word, 32'h0);
      // Every level in turn from index zero
      for (int i = 0; i < 3; i++) begin
         ask(32'h4, i, 32'h0);
         desc(5'(i + 1), (i == 2) ? 3'h2 : 3'h1);
      end
      // Geometry of the unified level, all plus-one encoded
      chk({22'h0, result.second_result_word[31:22]}, 32'h0000_000f);
      chk({20'h0, result.second_result_word[11:0]}, 32'h0000_003f);
      chk(result.set_count_word, 32'h0000_0fff);
      chk({31'h0, result.first_result_word[9]}, 32'h0);
      chk({22'h0, result.second_result_word[21:12]}, 32'h0);
      // Size from the fields: 16 ways, 1 partition, 64-byte lines, 4096 sets
      chk((result.second_result_word[31:22] + 32'h1) * (result.second_result_word[21:12] + 32'h1)
          * (result.second_result_word[11:0] + 32'h1) * (result.set_count_word + 32'h1), 32'h0040_0000);
      // Past the last cache, including the largest index
      ask(32'h4, 32'h3, 32'h0);
      desc(5'h0, 3'h0);
      ask(32'h4, 32'hffff_ffff, 32'h0);
      desc(5'h0, 3'h0);
      // Hidden range edges, and leaves just outside it
      ask(32'h4, 32'h0, LIMIT);
      zero(1'b1);
      @(posedge clk);
      #1;
      chk({31'h0, result_valid}, 32'h0);
      zero(1'b1);
      ask(32'h7fff_ffff, 32'h0, LIMIT);
      zero(1'b1);
      ask(32'h8000_0000, 32'h0, LIMIT);
      zero(1'b0);
      ask(32'h3, 32'h0, LIMIT);
      zero(1'b0);
      ask(32'h5, 32'h0, 32'h0);
      zero(1'b0);
      // Back-to-back queries, one answer each cycle
      @(posedge clk);
      query_valid <= 1'b1;
      query <= '{leaf: 32'h4, sub_index: 32'h0};
      misc_enable <= 32'h0;
      @(posedge clk);
      query <= '{leaf: 32'h4, sub_index: 32'h1};
      #1;
      chk({31'h0, result_valid}, 32'h1);
      desc(5'h1, 3'h1);
      @(posedge clk);
      query_valid <= 1'b0;
      #1;
      chk({31'h0, result_valid}, 32'h1);
      desc(5'h2, 3'h1);
      // Reset in the cycle in which an answer stands clears it at the next clock edge
      @(posedge clk);
      query_valid <= 1'b1;
      query <= '{leaf: 32'h4, sub_index: 32'h2};
      @(posedge clk);
      query_valid <= 1'b0;
      sys_rst <= 1'b1;
      #1;
      chk({31'h0, result_valid}, 32'h1);
      @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      chk(result.first_result_word, 32'h0);
      chk(result.second_result_word, 32'h0);
      chk({31'h0, result_valid}, 32'h0);
      chk({31'h0, leaf_hidden}, 32'h0);
      // First query straight after release is answered normally
      ask(32'h4, 32'h0, 32'h0);
      desc(5'h1, 3'h1);
      conclude();
   end
endmodule
`default_nettype wire
